// ### design/adc_pkg.sv
// constants and types shared by the converter control and its testbench
// assumes one reference clock of 25 MHz; all timing counts derive from it

package adc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_CONV_HS_NS = 3800;
  localparam int T_CONV_SLEEP_NS = 9800;
  localparam int T_WAKE_NS = 6000;
  localparam int T_HOLD_NS = 10;

  localparam int CNT_W = 8;
  // least times round up to whole cycles
  localparam logic [CNT_W-1:0] CONV_HS_CYC = CNT_W'((T_CONV_HS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CONV_SLEEP_CYC = CNT_W'((T_CONV_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WAKE_CYC = CNT_W'((T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // result word layout
  // ----------------------------------------------------------------
  localparam int CODE_W = 12;
  localparam int LEAD_ZEROS = 4;
  localparam int WORD_W = CODE_W + LEAD_ZEROS;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hF;
  localparam int RESULT_FIFO_DEPTH = 32;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SYNC_HIGH_RST = 3'h7;
  localparam logic [2:0] SYNC_LOW_RST = 3'h0;

  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_TRACK = 3'h0,
    ST_CONVERT = 3'h1,
    ST_DELIVER = 3'h2,
    ST_POWER_DOWN = 3'h3,
    ST_WAKE = 3'h4
  } conv_state_e;

  typedef enum logic [1:0] {
    SH_IDLE = 2'h0,
    SH_SHIFT = 2'h1,
    SH_HOLD = 2'h2
  } shift_state_e;

endpackage

// ### design/result_fifo.sv
// synchronous FIFO holding conversion results until the serial link takes them
// assumes both sides on one clock; valid/ready on each side

`timescale 1ns/1ps

module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic i_clk, // reference clock
  input wire logic i_resetn, // synchronous reset, active low
  input wire logic i_in_valid, // word offered
  output logic o_in_ready, // room for a word
  input wire logic [WIDTH-1:0] i_in_data, // word written
  output logic o_out_valid, // word available
  input wire logic i_out_ready, // drain takes the word
  output logic [WIDTH-1:0] o_out_data // oldest word
);

  localparam int PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_depth_check
    $error("result_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [PTR_W:0] next_count;
  logic do_push;
  logic do_pop;

  assign o_in_ready = (count != (PTR_W+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign do_push = i_in_valid && o_in_ready;
  assign do_pop = o_out_valid && i_out_ready;

  always_comb begin
    next_wr_ptr = do_push ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = do_pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = (PTR_W+1)'(count + 1'b1);
    end else if (do_pop && !do_push) begin
      next_count = (PTR_W+1)'(count - 1'b1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage has no reset; words are only read once counted in
  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

endmodule

// ### design/adc_conversion_serial_readout.sv
// conversion control and serial result readout of a 12-bit converter
// assumes convert-start and shift clock arrive as pins from the host and the
// raw converter code arrives from the converter core on the reference clock

`timescale 1ns/1ps

module adc_conversion_serial_readout
  import adc_pkg::*;
#(
  parameter bit BIPOLAR = 1'b1,
  parameter int FIFO_DEPTH = RESULT_FIFO_DEPTH
) (
  input wire logic i_ref_clk, // 25 MHz reference clock
  input wire logic i_resetn, // synchronous reset, active low
  input wire logic i_convert_start_n, // convert-start pin, edge sensitive
  input wire logic i_sclk, // host shift clock pin
  input wire logic [CODE_W-1:0] i_conv_code, // raw offset-binary code of the core
  output logic o_busy, // conversion in progress
  output logic o_hold, // 1 = track/hold holding
  output logic o_power_down, // device powered down
  output logic o_serial_result_out, // serial data bit
  output logic o_serial_result_oe // serial data drive enable
);

  if (FIFO_DEPTH < 2) begin : g_param_check
    $error("FIFO_DEPTH must be at least 2");
  end

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] cs_sync;
  logic [2:0] sclk_sync;
  logic cs_fall;
  logic cs_rise;
  logic cs_level;
  logic sclk_fall;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      cs_sync <= SYNC_HIGH_RST;
      sclk_sync <= SYNC_LOW_RST;
    end else begin
      cs_sync <= {cs_sync[1:0], i_convert_start_n};
      sclk_sync <= {sclk_sync[1:0], i_sclk};
    end
  end

  // stage 0 feeds stage 1 only; edges compare stages 1 and 2
  assign cs_level = cs_sync[1];
  assign cs_fall = cs_sync[2] && !cs_sync[1];
  assign cs_rise = !cs_sync[2] && cs_sync[1];
  assign sclk_fall = sclk_sync[2] && !sclk_sync[1];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_busy(input conv_state_e s);
    is_busy = (s == ST_CONVERT) || (s == ST_DELIVER);
  endfunction

  function automatic logic [CODE_W-1:0] code_result(input logic [CODE_W-1:0] raw);
    // flipping the MSB of offset binary gives two's complement
    code_result = BIPOLAR ? {~raw[CODE_W-1], raw[CODE_W-2:0]} : raw;
  endfunction

  // ----------------------------------------------------------------
  // conversion control
  // ----------------------------------------------------------------
  conv_state_e state;
  conv_state_e next_state;
  logic [CNT_W-1:0] conv_cnt;
  logic [CNT_W-1:0] next_conv_cnt;
  logic [CNT_W-1:0] wake_cnt;
  logic [CNT_W-1:0] next_wake_cnt;
  logic waking;
  logic next_waking;
  logic wake_done;
  logic next_wake_done;
  logic from_wake;
  logic next_from_wake;
  logic [CODE_W-1:0] result;
  logic [CODE_W-1:0] next_result;
  logic next_busy;
  logic next_hold;
  logic next_power_down;
  logic [CNT_W-1:0] conv_len;
  logic fifo_in_ready;

  assign conv_len = from_wake ? CONV_SLEEP_CYC : CONV_HS_CYC;

  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_wake_cnt = wake_cnt;
    next_waking = waking;
    next_wake_done = wake_done;
    next_from_wake = from_wake;
    next_result = result;
    // wake-up timer runs from the rising edge, independent of the state
    if (waking) begin
      if (wake_cnt == WAKE_CYC - 1'b1) begin
        next_waking = 1'b0;
        next_wake_done = 1'b1;
      end else begin
        next_wake_cnt = CNT_W'(wake_cnt + 1'b1);
      end
    end
    case (state)
      ST_TRACK: begin
        if (cs_fall) begin
          next_state = ST_CONVERT;
          next_conv_cnt = '0;
          next_from_wake = 1'b0;
        end
      end
      ST_CONVERT: begin
        // further falling edges are not looked at here
        if (conv_cnt == conv_len - 1'b1) begin
          next_state = ST_DELIVER;
          next_result = code_result(i_conv_code);
        end else begin
          next_conv_cnt = CNT_W'(conv_cnt + 1'b1);
        end
      end
      ST_DELIVER: begin
        // a full buffer stretches busy rather than losing a result
        if (fifo_in_ready) begin
          next_state = cs_level ? ST_TRACK : ST_POWER_DOWN;
        end
      end
      ST_POWER_DOWN: begin
        if (cs_rise) begin
          next_state = ST_WAKE;
          next_waking = 1'b1;
          next_wake_cnt = '0;
          next_wake_done = 1'b0;
        end
      end
      ST_WAKE: begin
        if (cs_fall) begin
          next_state = ST_CONVERT;
          next_conv_cnt = '0;
          next_from_wake = 1'b1;
        end else if (wake_done) begin
          next_state = ST_TRACK;
        end
      end
      default: begin
        next_state = ST_TRACK;
      end
    endcase
    next_busy = is_busy(next_state);
    // in sleep mode the hold waits for the wake timer; tracking resumes at end
    next_hold = (next_state == ST_CONVERT && (!next_from_wake || next_wake_done))
      || next_state == ST_DELIVER;
    next_power_down = (next_state == ST_POWER_DOWN);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state <= ST_TRACK;
      conv_cnt <= '0;
      wake_cnt <= '0;
      waking <= 1'b0;
      wake_done <= 1'b0;
      from_wake <= 1'b0;
      result <= '0;
      o_busy <= 1'b0;
      o_hold <= 1'b0;
      o_power_down <= 1'b0;
    end else begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      wake_cnt <= next_wake_cnt;
      waking <= next_waking;
      wake_done <= next_wake_done;
      from_wake <= next_from_wake;
      result <= next_result;
      o_busy <= next_busy;
      o_hold <= next_hold;
      o_power_down <= next_power_down;
    end
  end

  // ----------------------------------------------------------------
  // result buffer
  // ----------------------------------------------------------------
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [CODE_W-1:0] fifo_out_data;

  result_fifo #(
    .WIDTH(CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_result_fifo (
    .i_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_in_valid(state == ST_DELIVER),
    .o_in_ready(fifo_in_ready),
    .i_in_data(result),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  shift_state_e sh_state;
  shift_state_e next_sh_state;
  logic [WORD_W-1:0] shreg;
  logic [WORD_W-1:0] next_shreg;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [BIT_CNT_W-1:0] next_bit_cnt;
  logic [CNT_W-1:0] hold_cnt;
  logic [CNT_W-1:0] next_hold_cnt;
  logic next_oe;

  // the link stalls the buffer while a word is on the wire
  assign fifo_out_ready = (sh_state == SH_IDLE);

  always_comb begin
    next_sh_state = sh_state;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_hold_cnt = hold_cnt;
    next_oe = o_serial_result_oe;
    case (sh_state)
      SH_IDLE: begin
        if (fifo_out_valid) begin
          next_shreg = {{LEAD_ZEROS{1'b0}}, fifo_out_data};
          next_bit_cnt = '0;
          next_oe = 1'b1;
          next_sh_state = SH_SHIFT;
        end
      end
      SH_SHIFT: begin
        if (sclk_fall) begin
          if (bit_cnt == LAST_BIT) begin
            next_sh_state = SH_HOLD;
            next_hold_cnt = '0;
          end else begin
            next_shreg = {shreg[WORD_W-2:0], 1'b0};
            next_bit_cnt = BIT_CNT_W'(bit_cnt + 1'b1);
          end
        end
      end
      SH_HOLD: begin
        // last bit kept driven for the hold time, then the line is let go
        if (hold_cnt == HOLD_CYC - 1'b1) begin
          next_oe = 1'b0;
          next_sh_state = SH_IDLE;
        end else begin
          next_hold_cnt = CNT_W'(hold_cnt + 1'b1);
        end
      end
      default: begin
        next_sh_state = SH_IDLE;
        next_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      sh_state <= SH_IDLE;
      shreg <= '0;
      bit_cnt <= '0;
      hold_cnt <= '0;
      o_serial_result_oe <= 1'b0;
    end else begin
      sh_state <= next_sh_state;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      hold_cnt <= next_hold_cnt;
      o_serial_result_oe <= next_oe;
    end
  end

  assign o_serial_result_out = shreg[WORD_W-1];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  localparam int HS_D = CONV_HS_CYC;
  localparam int SL_D = CONV_SLEEP_CYC;
  localparam int WK_D = WAKE_CYC + 1;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence seq_fast_start;
    $rose(o_busy) && !from_wake;
  endsequence

  sequence seq_sleep_start;
    $rose(o_busy) && from_wake;
  endsequence

  sequence seq_last_fall;
    sh_state == SH_SHIFT && sclk_fall && bit_cnt == LAST_BIT;
  endsequence

  sequence seq_hold_then_release;
    o_serial_result_oe && o_serial_result_out == $past(o_serial_result_out) ##1 !o_serial_result_oe;
  endsequence

  AST_START_BUSY_HOLD: assert property (
    (state == ST_TRACK && cs_fall) |=> o_busy && o_hold)
    else $error("start edge did not raise busy and hold");

  AST_FAST_CONV_TIME: assert property (
    seq_fast_start |-> ##HS_D state == ST_DELIVER)
    else $error("fast conversion length wrong");

  AST_SLEEP_CONV_TIME: assert property (
    seq_sleep_start |-> ##SL_D state == ST_DELIVER)
    else $error("sleep conversion length wrong");

  AST_IGNORE_RESTART: assert property (
    (state == ST_CONVERT && cs_fall) |=>
      (state == ST_DELIVER || conv_cnt == CNT_W'($past(conv_cnt) + 1'b1)))
    else $error("conversion disturbed by a start edge");

  AST_POWER_DOWN: assert property (
    (state == ST_DELIVER && fifo_in_ready && !cs_level) |=> o_power_down && !o_busy)
    else $error("no power down with start low at end");

  AST_WAKE_UP: assert property (
    (o_power_down && cs_rise) |=> !o_power_down && state == ST_WAKE)
    else $error("rising edge did not wake the device");

  AST_WAKE_HOLD_DELAY: assert property (
    (state == ST_POWER_DOWN && cs_rise) |-> ##WK_D $rose(wake_done))
    else $error("wake timer length wrong");

  AST_TRACK_AT_END: assert property (
    $fell(o_busy) |-> !o_hold)
    else $error("track/hold not tracking after conversion");

  AST_CODING: assert property (
    (state == ST_CONVERT && next_state == ST_DELIVER) |=>
      result[CODE_W-1] == (BIPOLAR ^ $past(i_conv_code[CODE_W-1])))
    else $error("result coding wrong");

  AST_LEAD_ZEROS: assert property (
    (sh_state == SH_IDLE && fifo_out_valid) |=>
      o_serial_result_oe && shreg[WORD_W-1:CODE_W] == '0)
    else $error("word does not open with four zeros");

  AST_SHIFT_ON_FALL: assert property (
    (sh_state == SH_SHIFT && sclk_fall && bit_cnt != LAST_BIT) |=>
      o_serial_result_out == $past(shreg[WORD_W-2]))
    else $error("next bit not presented on falling edge");

  AST_RELEASE: assert property (
    seq_last_fall |=> seq_hold_then_release)
    else $error("line not held then released after last bit");

endmodule

// ### verif/adc_host_model.sv
// host model: drives the shift clock and collects one 16-bit result word
// assumes the bench reference clock; a frame starts when i_go is high at an edge

`timescale 1ns/1ps

module adc_host_model (
  input wire logic i_clk, // bench reference clock
  input wire logic i_go, // request one frame
  input wire logic [3:0] i_half_cyc, // clocks per shift-clock half period
  input wire logic i_serial_bit, // serial line as seen at the wire
  input wire logic i_oe, // device drive enable
  output logic o_sclk, // shift clock to the device
  output logic [15:0] o_word, // captured word
  output logic o_oe_ok, // enable was high at every capture
  output logic o_done // frame finished
);
  initial begin
    o_sclk = 1'b0;
    o_word = 16'h0000;
    o_oe_ok = 1'b0;
    o_done = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        #1;
        o_done = 1'b0;
        o_oe_ok = 1'b1;
        for (int i = 0; i < 16; i++) begin
          o_sclk = 1'b1;
          repeat (i_half_cyc) @(posedge i_clk);
          #1;
          // the old bit still stands at the fall, so it is taken there
          o_word = {o_word[14:0], i_serial_bit};
          o_oe_ok = o_oe_ok & i_oe;
          o_sclk = 1'b0;
          repeat (i_half_cyc) @(posedge i_clk);
          #1;
        end
        // clock stays parked low until the next frame
        o_done = 1'b1;
      end
    end
  end
endmodule

// ### verif/adc_conversion_serial_readout_tb_top.sv
// bench for the converter control: a bipolar and a unipolar instance side by side
// assumes the host model in its own file; both sides get the same pins

`timescale 1ns/1ps

module adc_conversion_serial_readout_tb_top;
  import adc_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic convert_start_n = 1'b1;
  logic [CODE_W-1:0] conv_code = 12'h000;
  logic go = 1'b0;
  logic [3:0] half_cyc = 4'h4;
  logic [1:0] busy, hold, power_down, sdo, oe, sclk, oe_ok, done, wire_bit;
  logic [1:0] last_bit = 2'b00;
  logic [15:0] word [2];
  int n_errors = 0;
  int checks = 0;

  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // devices and host models
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_side
    // side 0 is the bipolar variant, side 1 the unipolar one
    adc_conversion_serial_readout #(.BIPOLAR(g == 0), .FIFO_DEPTH(RESULT_FIFO_DEPTH)) i_adc_conversion_serial_readout (
      .i_ref_clk(ref_clk),
      .i_resetn(resetn),
      .i_convert_start_n(convert_start_n),
      .i_sclk(sclk[g]),
      .i_conv_code(conv_code),
      .o_busy(busy[g]),
      .o_hold(hold[g]),
      .o_power_down(power_down[g]),
      .o_serial_result_out(sdo[g]),
      .o_serial_result_oe(oe[g])
    );
    // a released line shows the inverse of its last bit, never a stale copy
    always @(posedge ref_clk) begin
      if (oe[g]) last_bit[g] <= sdo[g];
    end
    assign wire_bit[g] = oe[g] ? sdo[g] : ~last_bit[g];
    adc_host_model i_adc_host_model (
      .i_clk(ref_clk),
      .i_go(go),
      .i_half_cyc(half_cyc),
      .i_serial_bit(wire_bit[g]),
      .i_oe(oe[g]),
      .o_sclk(sclk[g]),
      .o_word(word[g]),
      .o_oe_ok(oe_ok[g]),
      .o_done(done[g])
    );
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // pin falls; returns at the first sample with busy high
  // after a wake-up the hold waits for the wake timer, so it is still low here
  task automatic start_conv(input logic [11:0] code, input bit keep_low, input bit wake);
    int n;
    conv_code = code;
    convert_start_n = 1'b0;
    n = 0;
    while (busy[0] !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    check("busy rise clocks", 16'(n >= 3 && n <= 4), 16'h1);
    check("hold with busy", 16'({busy, hold}), wake ? 16'hC : 16'hF);
    if (!keep_low) convert_start_n = 1'b1;
  endtask

  task automatic wait_busy_end(output int n);
    n = 0;
    while (busy[0] === 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
  endtask

  task automatic read_word(input logic [11:0] code, input bit rel);
    int n;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(1);
    n = 0;
    while (done[0] !== 1'b1 && n < 600) begin
      tick(1);
      n++;
    end
    check("bipolar word", word[0], {4'h0, code ^ 12'h800});
    check("unipolar word", word[1], {4'h0, code});
    check("driven at captures", 16'(oe_ok), 16'h3);
    tick(2);
    if (rel) check("line released", 16'(oe), 16'h0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic scn_fast(input logic [11:0] code);
    int n;
    start_conv(code, 1'b0, 1'b0);
    wait_busy_end(n);
    check("fast busy clocks", 16'(n), 16'(CONV_HS_CYC) + 16'h1);
    check("track, awake", 16'({hold, power_down}), 16'h0);
    tick(8); // acquisition time before anything else
    read_word(code, 1'b1); // read only while idle
  endtask

  task automatic scn_ignore();
    int n;
    start_conv(12'h3C3, 1'b0, 1'b0);
    tick(20);
    convert_start_n = 1'b0;
    tick(4);
    convert_start_n = 1'b1;
    wait_busy_end(n);
    check("busy with late fall", 16'(n + 24), 16'(CONV_HS_CYC) + 16'h1);
    tick(30);
    check("no second conversion", 16'(busy), 16'h0);
    read_word(12'h3C3, 1'b1);
  endtask

  task automatic scn_sleep();
    int n;
    start_conv(12'h123, 1'b1, 1'b0);
    wait_busy_end(n);
    check("power down at end", 16'({power_down, hold}), 16'hC);
    tick(20);
    check("stays down", 16'(power_down), 16'h3);
    convert_start_n = 1'b1;
    tick(30);
    start_conv(12'hE07, 1'b1, 1'b1);
    tick(100);
    check("hold waits wake", 16'({busy, hold}), 16'hC);
    tick(25);
    check("hold after wake", 16'({busy, hold, power_down}), 16'h3C);
    convert_start_n = 1'b1;
    wait_busy_end(n);
    check("sleep busy clocks", 16'(n + 125), 16'(CONV_SLEEP_CYC) + 16'h1);
    check("awake after sleep", 16'({hold, power_down}), 16'h0);
    tick(8);
    read_word(12'h123, 1'b0);
    read_word(12'hE07, 1'b1);
  endtask

  // fills shifter and buffer until busy stretches, then drains it
  task automatic scn_fifo();
    int n;
    for (int i = 0; i < RESULT_FIFO_DEPTH + 2; i++) begin
      start_conv(12'(i * 97), 1'b0, 1'b0);
      if (i < RESULT_FIFO_DEPTH + 1) begin
        wait_busy_end(n);
        tick(8);
      end
    end
    tick(120);
    check("busy stretched when full", 16'(busy), 16'h3);
    read_word(12'h000, 1'b0);
    wait_busy_end(n);
    check("busy ends once room", 16'(busy), 16'h0);
    for (int i = 1; i < RESULT_FIFO_DEPTH + 2; i++) begin
      read_word(12'(i * 97), i == RESULT_FIFO_DEPTH + 1);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    tick(2);
    resetn = 1'b1;
    tick(1);
    check("reset outputs", 16'({busy, hold, power_down, oe}), 16'h0);
    scn_fast(12'h000);
    scn_fast(12'hFFF);
    scn_fast(12'h800);
    scn_fast(12'h7FF);
    scn_fast(12'hA5C);
    scn_ignore();
    scn_sleep();
    scn_fifo();
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    finish_test();
  end
endmodule
